/* File: ahfs_axis.sv */
`timescale 1ns/1ps
// Axis homing, current, encoder and fault status block
module ahfs_axis
	import ahfs_pkg::*;
#(
	parameter int MS_CYCLES    = MS_CYC,
	parameter int STILL_CYCLES = STILL_CYC
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        left_switch,
	input  wire logic        right_switch,
	input  wire logic [31:0] actual_position,
	input  wire logic        velocity_zero,
	input  wire logic        accel_phase,
	input  wire logic        motion_command,
	input  wire logic        stall_event,
	input  wire logic        step_pulse,
	input  wire logic [6:0]  driver_flags,
	input  wire logic [9:0]  load_value,
	input  wire logic [9:0]  sensor_angle,
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	output logic             homing_active,
	output logic             homing_dir_right,
	output logic [10:0]      homing_speed,
	output logic             position_clear,
	output logic [7:0]       current_limit,
	output logic             standby_active,
	output logic             power_off,
	output logic             motor_stop
);
	ahfs_state_t s_r;          // Registered state
	ahfs_state_t s_nxt;        // Next state
	logic        ms_tick;      // 1 ms enable
	logic        enc_up;       // Encoder count up
	logic        enc_down;     // Encoder count down
	logic [9:0]  idx;          // Register index
	logic        setup_ph;     // APB setup cycle
	logic        wr_acc;       // Write access edge
	logic        swap;         // Right replaces left
	logic        ref_sw;       // Reference switch level
	logic        far_sw;       // Opposite switch level
	logic        ref_right;    // Reference lies to the right
	logic [32:0] dev_diff;     // Position minus encoder
	logic [32:0] dev_abs;      // Magnitude of deviation
	logic        dev_hit;      // Deviation beyond limit
	logic        motion_start; // Any motion command
	logic        err_clr;      // Error clear by read

	// Millisecond enable
	ahfs_tick #(.CYC(MS_CYCLES)) u_tick (
		.ref_clk (ref_clk),
		.rst     (rst),
		.tick    (ms_tick)
	);

	// Encoder phase decoder
	ahfs_quad u_quad (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.enc_a    (enc_a),
		.enc_b    (enc_b),
		.cnt_up   (enc_up),
		.cnt_down (enc_down)
	);

	// Which indices are mapped
	function automatic logic reg_mapped(input logic [9:0] i);
		case (i)
			IDX_HOMING_MODE, IDX_COARSE_SPEED, IDX_FINE_SPEED, IDX_SWITCH_SPAN,
			IDX_CAPTURED_POS, IDX_ACCEL_CUR, IDX_POWER_CUT, IDX_LOAD, IDX_STICKY_ERR,
			IDX_DRV_FAULT, IDX_ENC_COUNT, IDX_ENC_DIV, IDX_DEV_LIMIT, IDX_STANDBY_DLY,
			IDX_ROT_ANGLE, IDX_HOMING_CMD, IDX_RUN_CUR, IDX_HOMING_STAT: reg_mapped = 1'b1;
			default: reg_mapped = 1'b0;
		endcase
	endfunction

	// Which indices refuse writes
	function automatic logic reg_readonly(input logic [9:0] i);
		case (i)
			IDX_SWITCH_SPAN, IDX_CAPTURED_POS, IDX_LOAD, IDX_STICKY_ERR,
			IDX_DRV_FAULT, IDX_ROT_ANGLE, IDX_HOMING_STAT: reg_readonly = 1'b1;
			default: reg_readonly = 1'b0;
		endcase
	endfunction

	// Address decode and bus answer
	assign idx      = paddr[11:2];
	assign setup_ph = psel && !penable;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && ((paddr[1:0] != 2'b00) || !reg_mapped(idx)
		|| (pwrite && reg_readonly(idx)));
	assign wr_acc   = psel && penable && pwrite && !pslverr;
	assign prdata   = s_r.prdata;

	// Switch selection for the search
	// right replaces left
	assign swap      = s_r.mode[MODE_SWAP_BIT];
	assign ref_sw    = swap ? right_switch : left_switch;
	assign far_sw    = swap ? left_switch : right_switch;
	assign ref_right = swap ^ s_r.mode[MODE_REV_BIT];

	// Deviation between commanded and encoder position
	assign dev_diff = {actual_position[31], actual_position} - {s_r.enc[31], s_r.enc};
	assign dev_abs  = dev_diff[32] ? 33'(-dev_diff) : dev_diff;
	assign dev_hit  = (s_r.dev_lim != 32'h0000_0000) && (dev_abs > {1'b0, s_r.dev_lim});

	assign motion_start = motion_command || (wr_acc && idx == IDX_HOMING_CMD);
	assign err_clr      = psel && penable && !pwrite && !pslverr && idx == IDX_STICKY_ERR;

	// Next state of the whole block
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pos_clr = 1'b0;

		// Register writes
		if (wr_acc)
		begin
			case (idx)
				IDX_HOMING_MODE:  s_nxt.mode = pwdata[7:0];
				IDX_COARSE_SPEED: s_nxt.coarse = pwdata[10:0];
				IDX_FINE_SPEED:   s_nxt.fine = pwdata[10:0];
				IDX_ACCEL_CUR:    s_nxt.boost = pwdata[7:0];
				IDX_POWER_CUT:    s_nxt.fw_dly = pwdata[15:0];
				IDX_ENC_DIV:      s_nxt.enc_div = pwdata;
				IDX_DEV_LIMIT:    s_nxt.dev_lim = pwdata;
				IDX_STANDBY_DLY:  s_nxt.sb_dly = pwdata[15:0];
				IDX_RUN_CUR:      s_nxt.run_cur = pwdata[7:0];
				default:          s_nxt.run_cur = s_nxt.run_cur;
			endcase
		end

		// Encoder counter, software write wins
		// signed writable counter
		if (wr_acc && idx == IDX_ENC_COUNT)
			s_nxt.enc = pwdata;
		else if (enc_up)
			s_nxt.enc = s_r.enc + 32'h0000_0001;
		else if (enc_down)
			s_nxt.enc = s_r.enc - 32'h0000_0001;

		// Deviation stop, released by next motion command
		// stop on deviation
		if (dev_hit)
			s_nxt.dev_stop = 1'b1;
		else if (motion_start)
			s_nxt.dev_stop = 1'b0;

		// Sticky errors: clear only bits seen by the read, set wins
		// clear on read or motion
		if (motion_start)
			s_nxt.err = 2'b00;
		else if (err_clr)
			s_nxt.err = s_r.err & ~s_r.prdata[1:0];
		if (stall_event)
			s_nxt.err[ERR_STALL_BIT] = 1'b1;
		if (dev_hit)
			s_nxt.err[ERR_DEV_BIT] = 1'b1;

		// Homing sequencer
		case (s_r.hstate)
			H_IDLE:
			begin
				if (wr_acc && idx == IDX_HOMING_CMD && !dev_hit)
				begin
					if (s_r.mode[1:0] == 2'd1)
						s_nxt.hstate = H_SEEK_REF;
					else if (s_r.mode[1:0] != 2'd0)
						s_nxt.hstate = H_SEEK_FAR;
				end
			end
			H_SEEK_FAR:
			begin
				if (far_sw)
				begin
					s_nxt.first_pos = actual_position;
					s_nxt.hstate = H_SEEK_REF;
				end
			end
			H_SEEK_REF:
			begin
				if (ref_sw)
					s_nxt.hstate = H_BACKOFF;
			end
			H_BACKOFF:
			begin
				// Switching point found when switch releases
				if (!ref_sw)
				begin
					s_nxt.cap_pos = actual_position;
					s_nxt.pos_clr = 1'b1;
					// span for modes 2 and 3
					if (s_r.mode[1:0] != 2'd1)
						s_nxt.span = s_r.first_pos - actual_position;
					s_nxt.hstate = H_IDLE;
				end
			end
			default:
				s_nxt.hstate = H_IDLE;
		endcase
		// Deviation stop aborts a search
		if (dev_hit)
			s_nxt.hstate = H_IDLE;

		// Standstill detector on the step input
		// no step for many cycles
		if (step_pulse)
		begin
			s_nxt.still_cnt = '0;
			s_nxt.still = 1'b0;
		end
		else if (s_r.still_cnt >= 21'(STILL_CYCLES - 1))
			s_nxt.still = 1'b1;
		else
			s_nxt.still_cnt = s_r.still_cnt + 21'h00_0001;

		// Ten millisecond unit counter
		if (ms_tick)
			s_nxt.unit_cnt = (s_r.unit_cnt == 4'(MS_PER_UNIT - 1)) ? 4'h0
				: s_r.unit_cnt + 4'h1;

		// Power cut and standby timers, reset by motion
		if (!velocity_zero)
		begin
			s_nxt.fw_cnt = '0;
			s_nxt.power_off = 1'b0;
			s_nxt.sb_cnt = '0;
			s_nxt.standby = 1'b0;
		end
		else
		begin
			if (s_r.fw_dly == 16'h0000)
			begin
				s_nxt.fw_cnt = '0;
				s_nxt.power_off = 1'b0;
			end
			else if (s_r.fw_cnt >= s_r.fw_dly)
				s_nxt.power_off = 1'b1;
			else if (ms_tick)
				s_nxt.fw_cnt = s_r.fw_cnt + 16'h0001;
			if (s_r.sb_cnt >= s_r.sb_dly)
				s_nxt.standby = 1'b1;
			else if (ms_tick && s_r.unit_cnt == 4'(MS_PER_UNIT - 1))
				s_nxt.sb_cnt = s_r.sb_cnt + 16'h0001;
		end

		// Read data captured in the setup cycle
		if (setup_ph && !pwrite)
		begin
			case (idx)
				IDX_HOMING_MODE:  s_nxt.prdata = {24'h00_0000, s_r.mode};
				IDX_COARSE_SPEED: s_nxt.prdata = {21'h00_0000, s_r.coarse};
				IDX_FINE_SPEED:   s_nxt.prdata = {21'h00_0000, s_r.fine};
				IDX_SWITCH_SPAN:  s_nxt.prdata = s_r.span;
				IDX_CAPTURED_POS: s_nxt.prdata = s_r.cap_pos;
				IDX_ACCEL_CUR:    s_nxt.prdata = {24'h00_0000, s_r.boost};
				IDX_POWER_CUT:    s_nxt.prdata = {16'h0000, s_r.fw_dly};
				IDX_LOAD:         s_nxt.prdata = {22'h00_0000, load_value};
				IDX_STICKY_ERR:   s_nxt.prdata = {30'h0000_0000, s_r.err};
				IDX_DRV_FAULT:    s_nxt.prdata = {24'h00_0000, s_r.still, driver_flags};
				IDX_ENC_COUNT:    s_nxt.prdata = s_r.enc;
				IDX_ENC_DIV:      s_nxt.prdata = s_r.enc_div;
				IDX_DEV_LIMIT:    s_nxt.prdata = s_r.dev_lim;
				IDX_STANDBY_DLY:  s_nxt.prdata = {16'h0000, s_r.sb_dly};
				IDX_ROT_ANGLE:    s_nxt.prdata = {22'h00_0000, sensor_angle};
				IDX_RUN_CUR:      s_nxt.prdata = {24'h00_0000, s_r.run_cur};
				IDX_HOMING_STAT:  s_nxt.prdata = {29'h0000_0000, s_r.dev_stop,
					s_r.hstate};
				default:          s_nxt.prdata = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.fw_dly <= POWER_CUT_RST;
			s_r.sb_dly <= STANDBY_RST;
			s_r.run_cur <= RUN_CUR_RST;
			s_r.hstate <= H_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs toward motion controller and driver
	assign homing_active    = s_r.hstate != H_IDLE;
	assign homing_dir_right = (s_r.hstate == H_SEEK_REF) ? ref_right : !ref_right;
	assign homing_speed     = (s_r.hstate == H_BACKOFF) ? s_r.fine : s_r.coarse;
	assign position_clear   = s_r.pos_clr;
	assign current_limit    = (accel_phase && s_r.boost != 8'h00) ? s_r.boost : s_r.run_cur;
	assign standby_active   = s_r.standby;
	assign power_off        = s_r.power_off;
	assign motor_stop       = s_r.dev_stop;

	// Capture step of the search
	sequence seq_release;
		s_r.hstate == H_BACKOFF && !ref_sw;
	endsequence
	sequence seq_capture;
		position_clear && s_r.hstate == H_IDLE;
	endsequence

	chk_pos_capture: assert property (@(posedge ref_clk) disable iff (rst)
		seq_release |=> seq_capture and s_r.cap_pos == $past(actual_position))
		else $error("position not captured at switch release");
	chk_boost_sel: assert property (@(posedge ref_clk) disable iff (rst)
		accel_phase && s_r.boost != 8'h00 |-> current_limit == s_r.boost)
		else $error("boost current not applied");
	chk_fw_never: assert property (@(posedge ref_clk) disable iff (rst)
		s_r.fw_dly == 16'h0000 |=> !power_off)
		else $error("power cut with zero delay");
	chk_err_clear: assert property (@(posedge ref_clk) disable iff (rst)
		err_clr && !stall_event && !dev_hit && !motion_start |=> (s_r.err & $past(s_r.prdata[1:0])) == 2'b00)
		else $error("error flags not cleared by read");
	chk_dev_stop: assert property (@(posedge ref_clk) disable iff (rst)
		dev_hit |=> motor_stop && s_r.err[ERR_DEV_BIT])
		else $error("deviation did not stop motor");
	chk_still_flag: assert property (@(posedge ref_clk) disable iff (rst)
		step_pulse |=> !s_r.still && s_r.still_cnt == 21'h00_0000)
		else $error("standstill not cleared by step");
	// mode 1 goes straight to reference
	chk_mode_one: assert property (@(posedge ref_clk) disable iff (rst)
		s_r.hstate == H_IDLE && wr_acc && idx == IDX_HOMING_CMD && s_r.mode[1:0] == 2'd1
		&& !dev_hit |=> s_r.hstate == H_SEEK_REF)
		else $error("mode 1 did not seek reference first");
	// far switch leads to reference seek
	chk_far_first: assert property (@(posedge ref_clk) disable iff (rst)
		s_r.hstate == H_SEEK_FAR && far_sw && !dev_hit |=> s_r.hstate == H_SEEK_REF
		&& s_r.first_pos == $past(actual_position))
		else $error("far switch not handled");
	chk_rev_dir: assert property (@(posedge ref_clk) disable iff (rst)
		s_r.hstate == H_SEEK_REF |-> homing_dir_right == (swap ^ s_r.mode[MODE_REV_BIT]))
		else $error("search direction wrong");
endmodule

/* File: ahfs_pkg.sv */
// What this block does
// - Mode 1: seek left switch only
// - Mode 2: seek right, then left
// - Mode 3: right, then series home switch
// - Plus 4: right switch replaces left
// - Plus 128: reverse search direction
// - Coarse search speed 0..2047 toward switch
// - Modes 2/3 report end switch span
// - Capture position before clearing it
// - Boost current when accelerating, 0 means run
// - Power cut after ms delay, 0 never
// - Load measurement readable, 0..1023
// - Error bits: 1 stall, 2 deviation
// - Error bits clear on read or motion
// - Fault bits 0..2: stall, shutdown, warning
// - Fault bits 3,4: coil shorts
// - Fault bit 7: no step for 2^20
// - Signed 32-bit writable encoder counter
// - Deviation beyond limit stops motor, 0 off
// - Standby after 10 ms units, default 200
// - Rotation angle readable, 0..1023
package ahfs_pkg;
	// Register indices, byte address is four times the index
	localparam logic [9:0] IDX_HOMING_MODE  = 10'h0c1;
	localparam logic [9:0] IDX_COARSE_SPEED = 10'h0c2;
	localparam logic [9:0] IDX_FINE_SPEED   = 10'h0c3;
	localparam logic [9:0] IDX_SWITCH_SPAN  = 10'h0c4;
	localparam logic [9:0] IDX_CAPTURED_POS = 10'h0c5;
	localparam logic [9:0] IDX_ACCEL_CUR    = 10'h0c8;
	localparam logic [9:0] IDX_POWER_CUT    = 10'h0cc;
	localparam logic [9:0] IDX_LOAD         = 10'h0ce;
	localparam logic [9:0] IDX_STICKY_ERR   = 10'h0cf;
	localparam logic [9:0] IDX_DRV_FAULT    = 10'h0d0;
	localparam logic [9:0] IDX_ENC_COUNT    = 10'h0d1;
	localparam logic [9:0] IDX_ENC_DIV      = 10'h0d2;
	localparam logic [9:0] IDX_DEV_LIMIT    = 10'h0d4;
	localparam logic [9:0] IDX_STANDBY_DLY  = 10'h0d6;
	localparam logic [9:0] IDX_ROT_ANGLE    = 10'h0d7;
	localparam logic [9:0] IDX_HOMING_CMD   = 10'h0e0;
	localparam logic [9:0] IDX_RUN_CUR      = 10'h0e1;
	localparam logic [9:0] IDX_HOMING_STAT  = 10'h0e2;
	// Mode field positions
	localparam int MODE_SWAP_BIT = 2;
	localparam int MODE_REV_BIT  = 7;
	// Error bit positions
	localparam int ERR_STALL_BIT = 0;
	localparam int ERR_DEV_BIT   = 1;
	// Reset values
	localparam logic [15:0] POWER_CUT_RST = 16'h0000;
	localparam logic [15:0] STANDBY_RST   = 16'h00c8;
	localparam logic [7:0]  RUN_CUR_RST   = 8'hff;
	// Timing
	localparam int CLK_NS      = 10;
	localparam int MS_NS       = 1000000;
	localparam int MS_CYC      = MS_NS / CLK_NS;
	localparam int MS_PER_UNIT = 10;
	localparam int STILL_CYC   = 1048576;
	// Homing sequencer states
	typedef enum logic [1:0] {H_IDLE, H_SEEK_FAR, H_SEEK_REF, H_BACKOFF} ahfs_hstate_t;
	// All state of the main block
	typedef struct packed {
		logic [7:0]   mode;
		logic [10:0]  coarse;
		logic [10:0]  fine;
		logic [31:0]  span;
		logic [31:0]  cap_pos;
		logic [7:0]   boost;
		logic [15:0]  fw_dly;
		logic [1:0]   err;
		logic [31:0]  enc;
		logic [31:0]  enc_div;
		logic [31:0]  dev_lim;
		logic [15:0]  sb_dly;
		logic [7:0]   run_cur;
		ahfs_hstate_t hstate;
		logic [31:0]  first_pos;
		logic         pos_clr;
		logic         dev_stop;
		logic [20:0]  still_cnt;
		logic         still;
		logic [15:0]  fw_cnt;
		logic         power_off;
		logic [15:0]  sb_cnt;
		logic         standby;
		logic [3:0]   unit_cnt;
		logic [31:0]  prdata;
	} ahfs_state_t;
endpackage

/* File: ahfs_tick.sv */
`timescale 1ns/1ps
// One-cycle enable pulse every CYC clocks
module ahfs_tick
	import ahfs_pkg::*;
#(
	parameter int CYC = MS_CYC
)(
	input  wire logic ref_clk,
	input  wire logic rst,
	output logic      tick
);
	// Divider state
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} ahfs_tick_t;
	ahfs_tick_t s_r;
	ahfs_tick_t s_nxt;

	// Count down and pulse on wrap
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt == 32'h0000_0000)
		begin
			s_nxt.cnt = 32'(CYC - 1);
			s_nxt.tick = 1'b1;
		end
		else
			s_nxt.cnt = s_r.cnt - 32'h0000_0001;
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick = s_r.tick;
endmodule

/* File: ahfs_quad.sv */
`timescale 1ns/1ps
// Quadrature decoder, one up or down pulse per edge
module ahfs_quad (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic enc_a,
	input  wire logic enc_b,
	output logic      cnt_up,
	output logic      cnt_down
);
	// Previous phase pair
	typedef struct packed {
		logic [1:0] prev;
	} ahfs_quad_t;
	ahfs_quad_t s_r;
	ahfs_quad_t s_nxt;
	logic [3:0] trans;

	// Transition decode
	always_comb
	begin
		s_nxt.prev = {enc_a, enc_b};
		trans = {s_r.prev, enc_a, enc_b};
		cnt_up = (trans == 4'h1) || (trans == 4'h7) || (trans == 4'he) || (trans == 4'h8);
		cnt_down = (trans == 4'h2) || (trans == 4'hb) || (trans == 4'hd) || (trans == 4'h4);
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule

/* File: ahfs_far_side.sv */
`timescale 1ns/1ps
// Travel model of the axis with its two end switches
module ahfs_far_side #(
	parameter int EDGE = 12
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        homing_active,
	input  wire logic        homing_dir_right,
	input  wire logic        position_clear,
	output logic             left_switch,
	output logic             right_switch,
	output logic [31:0]      actual_position
);
	logic [1:0] div_r; // One step every four clocks

	// Position moves only while a search runs, cleared on request
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			div_r           <= 2'h0;
			actual_position <= 32'h0000_0000;
		end
		else
		begin
			div_r <= div_r + 2'h1;
			if (position_clear)
				actual_position <= 32'h0000_0000;
			else if (homing_active && div_r == 2'h0)
				actual_position <= homing_dir_right ? actual_position + 32'h0000_0001
					: actual_position - 32'h0000_0001;
		end
	end

	// Switches close at both travel ends, inactive in between
	assign left_switch  = $signed(actual_position) <= -EDGE;
	assign right_switch = $signed(actual_position) >= EDGE;
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the axis homing and status block
module testbench
	import ahfs_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, actual_position;
	logic        pready, pslverr, left_switch, right_switch;
	logic        velocity_zero = 1'b1, accel_phase = 1'b0, motion_command = 1'b0;
	logic        stall_event = 1'b0, step_pulse = 1'b0, enc_a = 1'b0, enc_b = 1'b0;
	logic [6:0]  driver_flags = 7'h00;
	logic [9:0]  load_value = 10'h000, sensor_angle = 10'h000;
	logic        homing_active, homing_dir_right, position_clear;
	logic        standby_active, power_off, motor_stop;
	logic [10:0] homing_speed;
	logic [7:0]  current_limit;
	logic [33:0] notes[$]; // Expected bus outcomes, oldest first
	logic [33:0] nt;
	logic [31:0] seed = 32'h0000_2d3e;
	logic [31:0] r;
	int          fails = 0, tests_run = 0;

	ahfs_axis #(.MS_CYCLES(20), .STILL_CYCLES(64)) dut (
		.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .left_switch, .right_switch, .actual_position, .velocity_zero,
		.accel_phase, .motion_command, .stall_event, .step_pulse, .driver_flags,
		.load_value, .sensor_angle, .enc_a, .enc_b, .homing_active, .homing_dir_right,
		.homing_speed, .position_clear, .current_limit, .standby_active, .power_off,
		.motor_stop
	);

	ahfs_far_side far_side (
		.ref_clk, .rst, .homing_active, .homing_dir_right, .position_clear,
		.left_switch, .right_switch, .actual_position
	);

	// Free-running clock
	always #5 ref_clk = ~ref_clk;

	// Pseudo-random source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Counts and verdict
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One bus transfer, expected outcome noted first
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
		input logic e);
		notes.push_back({~w & ~e, e, d});
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 1'b0);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b0, idx, d, 1'b0);
	endtask

	// Bus watcher takes the oldest note at each completed transfer
	always @(posedge ref_clk)
		if (psel && penable && pready)
		begin
			nt = notes.pop_front();
			check(32'(pslverr), 32'(nt[32]));
			if (nt[33])
				check(prdata, nt[31:0]);
		end

	// One full search, then captured values
	task automatic home(input logic [7:0] m, input logic d);
		logic [31:0] far;
		logic [31:0] rel;
		logic [10:0] sp;
		int          n;
		far = 32'h0000_0000;
		sp  = 11'h000;
		wr(IDX_HOMING_MODE, {24'h00_0000, m});
		wr(IDX_HOMING_CMD, 32'h0000_0000);
		check(32'(homing_active), 32'h0000_0001);
		check(32'(homing_dir_right), 32'(d));
		check(32'(homing_speed), 32'h0000_07ff);
		for (n = 0; n < 3000 && position_clear !== 1'b1; n++)
		begin
			if (far === 32'h0000_0000 && (m[2] ? left_switch : right_switch))
				far = actual_position;
			// Any speed other than coarse while searching is the back-off speed
			if (homing_active === 1'b1 && homing_speed !== 11'h7ff)
				sp = homing_speed;
			@(posedge ref_clk);
		end
		rel = actual_position;
		check(32'(position_clear), 32'h0000_0001);
		check(32'(sp), 32'h0000_0100);
		rd(IDX_CAPTURED_POS, rel);
		if (m[1])
			rd(IDX_SWITCH_SPAN, far - rel);
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(IDX_POWER_CUT, 32'h0000_0000);
		rd(IDX_STANDBY_DLY, 32'h0000_00c8);
		check(32'(power_off), 32'h0000_0000);
		wr(IDX_DEV_LIMIT, 32'h0000_0000);
		wr(IDX_COARSE_SPEED, 32'h0000_07ff);
		rd(IDX_COARSE_SPEED, 32'h0000_07ff);
		wr(IDX_FINE_SPEED, 32'h0000_0100); // Fine below coarse
		// Live values and fault flags, no steps for a while
		r = xs();
		load_value   <= r[9:0];
		sensor_angle <= r[19:10];
		driver_flags <= r[26:20];
		repeat (80) @(posedge ref_clk);
		rd(IDX_LOAD, {22'h00_0000, r[9:0]});
		rd(IDX_ROT_ANGLE, {22'h00_0000, r[19:10]});
		rd(IDX_DRV_FAULT, {24'h00_0000, 1'b1, r[26:20]});
		repeat (8)
		begin
			step_pulse <= 1'b1;
			@(posedge ref_clk);
			step_pulse <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
		rd(IDX_DRV_FAULT, {25'h000_0000, r[26:20]});
		// Refused accesses
		apb(1'b0, 10'h0c0, 32'h0000_0000, 1'b1);
		apb(1'b1, IDX_LOAD, 32'h0000_0000, 1'b1);
		// Sticky stall flag
		stall_event <= 1'b1;
		@(posedge ref_clk);
		stall_event <= 1'b0;
		rd(IDX_STICKY_ERR, 32'h0000_0001);
		rd(IDX_STICKY_ERR, 32'h0000_0000);
		stall_event <= 1'b1;
		@(posedge ref_clk);
		stall_event    <= 1'b0;
		motion_command <= 1'b1;
		@(posedge ref_clk);
		motion_command <= 1'b0;
		rd(IDX_STICKY_ERR, 32'h0000_0000);
		// Boost current and its fallback
		accel_phase <= 1'b1;
		wr(IDX_ACCEL_CUR, 32'h0000_0040);
		check(32'(current_limit), 32'h0000_0040);
		wr(IDX_ACCEL_CUR, 32'h0000_0000);
		check(32'(current_limit), 32'h0000_00ff);
		wr(IDX_RUN_CUR, 32'h0000_0080);
		check(32'(current_limit), 32'h0000_0080);
		accel_phase <= 1'b0;
		// Encoder two edges back, two forward
		wr(IDX_ENC_COUNT, 32'h8000_0000);
		enc_a <= 1'b1;
		repeat (4) @(posedge ref_clk);
		enc_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// Two steps back across the sign boundary
		rd(IDX_ENC_COUNT, 32'h7fff_fffe);
		enc_b <= 1'b0;
		repeat (4) @(posedge ref_clk);
		enc_a <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(IDX_ENC_COUNT, 32'h8000_0000);
		r = xs();
		wr(IDX_ENC_DIV, r);
		rd(IDX_ENC_DIV, r);
		// Search modes
		home(8'h01, 1'b0);
		home(8'h02, 1'b1);
		home(8'h03, 1'b1);
		home(8'h05, 1'b1);
		home(8'h06, 1'b0);
		check(32'(motor_stop), 32'h0000_0000);
		// Standstill timers
		velocity_zero <= 1'b0;
		wr(IDX_POWER_CUT, 32'h0000_0002);
		wr(IDX_STANDBY_DLY, 32'h0000_0002);
		velocity_zero <= 1'b1;
		repeat (15) @(posedge ref_clk);
		check(32'(power_off), 32'h0000_0000);
		repeat (35) @(posedge ref_clk);
		check(32'(power_off), 32'h0000_0001);
		repeat (100) @(posedge ref_clk);
		check(32'(standby_active), 32'h0000_0000);
		repeat (310) @(posedge ref_clk);
		check(32'(standby_active), 32'h0000_0001);
		velocity_zero <= 1'b0;
		// Reversed search stopped by deviation
		wr(IDX_ENC_COUNT, 32'h0000_0000);
		wr(IDX_DEV_LIMIT, 32'h0000_0003);
		wr(IDX_HOMING_MODE, 32'h0000_0081);
		wr(IDX_HOMING_CMD, 32'h0000_0000);
		check(32'(homing_dir_right), 32'h0000_0001);
		for (int n = 0; n < 200 && motor_stop !== 1'b1; n++)
			@(posedge ref_clk);
		check(32'(motor_stop), 32'h0000_0001);
		repeat (4) @(posedge ref_clk);
		check(32'(homing_active), 32'h0000_0000);
		rd(IDX_HOMING_STAT, 32'h0000_0004);
		wr(IDX_DEV_LIMIT, 32'h0000_0000);
		rd(IDX_STICKY_ERR, 32'h0000_0002);
		motion_command <= 1'b1;
		@(posedge ref_clk);
		motion_command <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(32'(motor_stop), 32'h0000_0000);
		rd(IDX_STICKY_ERR, 32'h0000_0000);
		complete_run();
	end

	// Hang guard, well beyond the expected run
	initial
	begin
		#200000;
		fails++;
		complete_run();
	end
endmodule
